// ==== porl_pkg.sv ====
// Package: register map, field layout and constants of the preset output line router
package porl_pkg;

    // ------------------------------------------------------------------
    // Sizing
    // ------------------------------------------------------------------
    localparam int NUM_PRESETS = 8;
    localparam int NUM_LINES = 4;
    localparam int PRESET_IDX_W = 3;
    localparam int LINE_IDX_W = 2;
    localparam int EXP_W = 24;
    localparam int GAIN_W = 16;
    localparam int SRC_W = 4;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXPOSURE = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h08;
    localparam logic [7:0] OFS_FF_TABLE = 8'h0C;
    localparam logic [7:0] OFS_LINE_SRC = 8'h10;
    localparam logic [7:0] OFS_LINE_VAL = 8'h14;
    localparam logic [7:0] OFS_LATCH_CMD = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_PRESET_LSB = 0;
    localparam int CTRL_LINE_LSB = 4;
    localparam int CTRL_ACTIVE_LSB = 8;
    localparam int CTRL_CYCLE_EXP_BIT = 12;
    localparam int CTRL_CYCLE_GAIN_BIT = 13;
    localparam int CTRL_CYCLE_FF_BIT = 14;
    localparam int CTRL_CYCLE_OUT_BIT = 15;
    localparam int CTRL_LATCH_BIT = 16;
    localparam int STATUS_LINE_LSB = 0;

    // First physical connector line served by output index 0
    localparam int FIRST_LINE_NUMBER = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [EXP_W-1:0] EXP_RESET = 24'h000064;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 16'h0100;
    localparam logic [EXP_W-1:0] STD_EXP_RESET = 24'h000064;
    localparam logic [GAIN_W-1:0] STD_GAIN_RESET = 16'h0100;

    // ------------------------------------------------------------------
    // Output pulse width
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYCLES = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        FF_TABLE_ONE,
        FF_TABLE_TWO,
        FF_TABLE_THREE,
        FF_TABLE_FOUR
    } porl_ff_table_type;

    typedef enum logic [SRC_W-1:0] {
        SRC_OFF,
        SRC_SW_LEVEL,
        SRC_FRAME_BEGIN_PULSE,
        SRC_LINE_BEGIN_PULSE,
        SRC_EXP_BEGIN_PULSE,
        SRC_EXP_FINISH_PULSE,
        SRC_RD_BEGIN_PULSE,
        SRC_RD_FINISH_PULSE,
        SRC_GOOD_TRIG_PULSE,
        SRC_BAD_TRIG_PULSE,
        SRC_ACQ_BEGIN_PULSE,
        SRC_ACQ_FINISH_PULSE,
        SRC_TMR_A_DONE_PULSE
    } porl_src_type;

    localparam int NUM_EVENTS = 11;

endpackage : porl_pkg

// ==== porl_pulse_stretch.sv ====
// Module: one output line's event pulse stretcher with a pending event count
`timescale 1ns/1ns
`default_nettype none
module porl_pulse_stretch
    import porl_pkg::*;
#(
    parameter int WIDTH_CYCLES = PULSE_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic event_in,
    output logic pulse_out
);
    localparam int CW = $clog2(WIDTH_CYCLES * 2 + 2);

    initial
    begin
        if (WIDTH_CYCLES < 1)
            $error("pulse width must be at least one cycle");
    end

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic pulse_reg;
    logic pulse_next;

    // ------------------------------------------------------------------
    // Pulse timing
    // ------------------------------------------------------------------
    // A low gap of one pulse width plus one cycle separates queued pulses, so back to
    // back events remain visible as separate pulses.
    always_comb
    begin
        count_next = count_reg;
        pend_next = pend_reg;
        pulse_next = pulse_reg;
        if (clear)
        begin
            count_next = '0;
            pend_next = '0;
            pulse_next = 1'b0;
        end
        else
        begin
            if (event_in && pend_reg != 4'hF)
                pend_next = pend_reg + 4'h1;
            if (count_reg != '0)
            begin
                count_next = count_reg - CW'(1);
                if (count_reg == CW'(WIDTH_CYCLES + 1))
                    pulse_next = 1'b0;
            end
            else if (pend_next != '0)
            begin
                pend_next = pend_next - 4'h1;
                count_next = CW'(WIDTH_CYCLES * 2);
                pulse_next = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= '0;
            pend_reg <= '0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            pend_reg <= pend_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse_out = pulse_reg;

endmodule : porl_pulse_stretch
`default_nettype wire

// ==== porl_router.sv ====
// Module: preset table, output line routing and AHB-Lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Per-preset register accesses go to the preset named by the select field.
// - Each preset stores an exposure time in microseconds, applied when active.
// - Each preset stores a gain factor, applied when active.
// - Each preset picks one of four flat-field tables.
// - Line select field picks connector line 3 to 6 for output settings.
// - Selected line drives exactly one source; off leaves the circuit open.
// - Software level source drives the line from the software value.
// - Frame-begin source pulses at each frame-active start.
// - Line-begin source pulses at each line-active start.
// - Exposure sources pulse at exposure start or end.
// - Readout sources pulse at readout start or end.
// - Good trigger source pulses per accepted line trigger.
// - Bad trigger source pulses per rejected line trigger.
// - Acquisition sources pulse at acquisition start or stop.
// - Timer-done source pulses each time the first timer ends.
// - Software value closes circuit when active; latch mode waits for command.
// - Cycling a feature makes the standard setting read-only; here standard exposure/gain is hidden, preset 0 ff/outputs stay writable.
module porl_router
    import porl_pkg::*;
#(
    parameter int PRESETS = NUM_PRESETS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frame_active,
    input wire logic line_active,
    input wire logic exposure_active,
    input wire logic readout_active,
    input wire logic acq_active,
    input wire logic good_trig_event,
    input wire logic bad_trig_event,
    input wire logic tmr_a_done_event,
    output logic [EXP_W-1:0] active_exposure_us,
    output logic [GAIN_W-1:0] active_gain_factor,
    output logic [1:0] active_ff_table,
    output logic [NUM_LINES-1:0] line_out,
    output logic [NUM_LINES-1:0] line_oe
);
    initial
    begin
        if (PRESETS < 1 || PRESETS > NUM_PRESETS)
            $error("preset count out of range");
    end

    // ------------------------------------------------------------------
    // Input synchronisers and edge events
    // ------------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] meta_reg;
    logic [NSYNC-1:0] sync_reg;
    logic [NSYNC-1:0] prev_reg;
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;
    logic [NUM_EVENTS-1:0] ev;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= {tmr_a_done_event, bad_trig_event, good_trig_event, acq_active,
                         readout_active, exposure_active, line_active, frame_active};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
    // Event order follows the pulse sources, starting at frame begin
    assign ev = {rise[7], fall[4], rise[4], rise[6], rise[5], fall[3], rise[3], fall[2],
                 rise[2], rise[1], rise[0]};

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [EXP_W-1:0] exp_reg [PRESETS];
    logic [EXP_W-1:0] exp_next [PRESETS];
    logic [GAIN_W-1:0] gain_reg [PRESETS];
    logic [GAIN_W-1:0] gain_next [PRESETS];
    logic [1:0] ff_reg [PRESETS];
    logic [1:0] ff_next [PRESETS];
    logic [SRC_W-1:0] src_reg [PRESETS][NUM_LINES];
    logic [SRC_W-1:0] src_next [PRESETS][NUM_LINES];
    logic [NUM_LINES-1:0] swv_reg [PRESETS];
    logic [NUM_LINES-1:0] swv_next [PRESETS];
    logic [NUM_LINES-1:0] latched_reg;
    logic [NUM_LINES-1:0] latched_next;
    logic [EXP_W-1:0] std_exp_reg;
    logic [EXP_W-1:0] std_exp_next;
    logic [GAIN_W-1:0] std_gain_reg;
    logic [GAIN_W-1:0] std_gain_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [NUM_LINES-1:0] line_out_reg;
    logic [NUM_LINES-1:0] line_out_next;
    logic [NUM_LINES-1:0] line_oe_reg;
    logic [NUM_LINES-1:0] line_oe_next;

    logic [PRESET_IDX_W-1:0] sel_p;
    logic [PRESET_IDX_W-1:0] act_p;
    logic [LINE_IDX_W-1:0] sel_l;
    logic latch_mode;
    logic addr_phase;
    logic [7:0] rd_addr;

    assign sel_p = ctrl_reg[CTRL_PRESET_LSB +: PRESET_IDX_W];
    assign act_p = ctrl_reg[CTRL_ACTIVE_LSB +: PRESET_IDX_W];
    assign sel_l = ctrl_reg[CTRL_LINE_LSB +: LINE_IDX_W];
    assign latch_mode = ctrl_reg[CTRL_LATCH_BIT];
    assign addr_phase = hsel && hready && htrans[1];
    assign rd_addr = haddr[7:0];

    // ------------------------------------------------------------------
    // Bus write and read next state
    // ------------------------------------------------------------------
    // Writes land in the data phase; the slave never stalls (zero waits).
    always_comb
    begin
        ctrl_next = ctrl_reg;
        exp_next = exp_reg;
        gain_next = gain_reg;
        ff_next = ff_reg;
        src_next = src_reg;
        swv_next = swv_reg;
        std_exp_next = std_exp_reg;
        std_gain_next = std_gain_reg;
        latched_next = latch_mode ? latched_reg : swv_reg[act_p];
        rdata_next = rdata_reg;
        wr_pend_next = addr_phase && hwrite;
        wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
        if (wr_pend_reg)
        begin
            case (wr_addr_reg)
                OFS_CTRL: ctrl_next = hwdata;
                OFS_EXPOSURE:
                    if (ctrl_reg[CTRL_CYCLE_EXP_BIT])
                        exp_next[sel_p] = hwdata[EXP_W-1:0];
                    else
                        std_exp_next = hwdata[EXP_W-1:0];
                OFS_GAIN:
                    if (ctrl_reg[CTRL_CYCLE_GAIN_BIT])
                        gain_next[sel_p] = hwdata[GAIN_W-1:0];
                    else
                        std_gain_next = hwdata[GAIN_W-1:0];
                OFS_FF_TABLE: ff_next[sel_p] = hwdata[1:0];
                OFS_LINE_SRC: src_next[sel_p][sel_l] = hwdata[SRC_W-1:0];
                OFS_LINE_VAL: swv_next[sel_p][sel_l] = hwdata[0];
                OFS_LATCH_CMD:
                    if (hwdata[0])
                        latched_next = swv_reg[act_p];
                default: ;
            endcase
        end
        if (addr_phase && !hwrite)
        begin
            case (rd_addr)
                OFS_CTRL: rdata_next = ctrl_reg;
                OFS_EXPOSURE: rdata_next = 32'(ctrl_reg[CTRL_CYCLE_EXP_BIT] ?
                                               exp_reg[sel_p] : std_exp_reg);
                OFS_GAIN: rdata_next = 32'(ctrl_reg[CTRL_CYCLE_GAIN_BIT] ?
                                           gain_reg[sel_p] : std_gain_reg);
                OFS_FF_TABLE: rdata_next = 32'(ff_reg[sel_p]);
                OFS_LINE_SRC: rdata_next = 32'(src_reg[sel_p][sel_l]);
                OFS_LINE_VAL: rdata_next = 32'(swv_reg[sel_p][sel_l]);
                OFS_STATUS: rdata_next = 32'(line_out_reg) << STATUS_LINE_LSB;
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Line routing
    // ------------------------------------------------------------------
    // Pulse stretchers run on every line regardless of source, so a
    // source change only picks a new, already settled level.
    logic [NUM_EVENTS-1:0] pulses [NUM_LINES];
    logic [SRC_W-1:0] cur_src [NUM_LINES];
    logic [NUM_LINES-1:0] sw_level;

    assign sw_level = latch_mode ? latched_reg : swv_reg[act_p];

    for (genvar l = 0; l < NUM_LINES; l++)
    begin : g_line
        // Standard (non cycling) routing uses preset zero's entry
        assign cur_src[l] = ctrl_reg[CTRL_CYCLE_OUT_BIT] ? src_reg[act_p][l] : src_reg[0][l];
        for (genvar e = 0; e < NUM_EVENTS; e++)
        begin : g_ev
            porl_pulse_stretch u_stretch (
                .hclk(hclk),
                .hresetn(hresetn),
                .clear(1'b0),
                .event_in(ev[e]),
                .pulse_out(pulses[l][e])
            );
        end
    end

    always_comb
    begin
        line_out_next = line_out_reg;
        line_oe_next = line_oe_reg;
        for (int l = 0; l < NUM_LINES; l++)
        begin
            case (porl_src_type'(cur_src[l]))
                SRC_OFF:
                begin
                    line_out_next[l] = 1'b0;
                    line_oe_next[l] = 1'b0;
                end
                SRC_SW_LEVEL:
                begin
                    line_out_next[l] = sw_level[l];
                    line_oe_next[l] = 1'b1;
                end
                default:
                begin
                    if (cur_src[l] <= SRC_W'(SRC_TMR_A_DONE_PULSE))
                    begin
                        line_out_next[l] = pulses[l][cur_src[l] - SRC_W'(SRC_FRAME_BEGIN_PULSE)];
                        line_oe_next[l] = 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= 32'h00000000;
            for (int p = 0; p < PRESETS; p++)
            begin
                exp_reg[p] <= EXP_RESET;
                gain_reg[p] <= GAIN_RESET;
                ff_reg[p] <= 2'h0;
                swv_reg[p] <= '0;
                for (int l = 0; l < NUM_LINES; l++)
                    src_reg[p][l] <= '0;
            end
            std_exp_reg <= STD_EXP_RESET;
            std_gain_reg <= STD_GAIN_RESET;
            latched_reg <= '0;
            rdata_reg <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            line_out_reg <= '0;
            line_oe_reg <= '0;
            active_exposure_us <= STD_EXP_RESET;
            active_gain_factor <= STD_GAIN_RESET;
            active_ff_table <= 2'h0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            exp_reg <= exp_next;
            gain_reg <= gain_next;
            ff_reg <= ff_next;
            src_reg <= src_next;
            swv_reg <= swv_next;
            std_exp_reg <= std_exp_next;
            std_gain_reg <= std_gain_next;
            latched_reg <= latched_next;
            rdata_reg <= rdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            line_out_reg <= line_out_next;
            line_oe_reg <= line_oe_next;
            // Cycling features take the active preset; others the standard value
            active_exposure_us <= ctrl_reg[CTRL_CYCLE_EXP_BIT] ? exp_reg[act_p] : std_exp_reg;
            active_gain_factor <= ctrl_reg[CTRL_CYCLE_GAIN_BIT] ? gain_reg[act_p] : std_gain_reg;
            active_ff_table <= ctrl_reg[CTRL_CYCLE_FF_BIT] ? ff_reg[act_p] : ff_reg[0];
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign line_out = line_out_reg;
    assign line_oe = line_oe_reg;

endmodule : porl_router
`default_nettype wire

// ==== porl_router_props.sv ====
// Checker: bus and output-cause properties of the preset output line router
`timescale 1ns/1ns
`default_nettype none
module porl_router_props
    import porl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [EXP_W-1:0] active_exposure_us,
    input wire logic [GAIN_W-1:0] active_gain_factor,
    input wire logic [1:0] active_ff_table,
    input wire logic [NUM_LINES-1:0] line_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // Bus tracking
    // ----------------------------------------
    // Settings only move after a completed write, so count cycles since one
    logic taken;
    logic wr_dp_reg, wr_dp_next, rd_dp_reg, rd_dp_next, unm_reg, unm_next;
    logic [2:0] since_wr_reg, since_wr_next;
    assign taken = hsel && hready && htrans[1];
    always_comb
    begin
        wr_dp_next = taken && hwrite;
        rd_dp_next = taken && !hwrite;
        unm_next = (haddr[7:5] != 3'h0) && (haddr[31:8] == 24'h0);
        since_wr_next = (since_wr_reg == 3'h7) ? since_wr_reg : since_wr_reg + 3'h1;
        if (wr_dp_reg)
        begin
            since_wr_next = 3'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_dp_reg <= 1'b0;
            rd_dp_reg <= 1'b0;
            unm_reg <= 1'b0;
            since_wr_reg <= 3'h7;
        end
        else
        begin
            wr_dp_reg <= wr_dp_next;
            rd_dp_reg <= rd_dp_next;
            unm_reg <= unm_next;
            since_wr_reg <= since_wr_next;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("hreadyout not high");
    resp_okay_a: assert property (taken ##1 1'b1 |-> hresp == 1'b0)
        else $error("hresp not OKAY");
    unmapped_zero_a: assert property (rd_dp_reg && unm_reg |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!taken |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    exp_cause_a: assert property ($changed(active_exposure_us) |-> since_wr_reg <= 3'h4)
        else $error("exposure changed without a write");
    gain_cause_a: assert property ($changed(active_gain_factor) |-> since_wr_reg <= 3'h4)
        else $error("gain changed without a write");
    ff_cause_a: assert property ($changed(active_ff_table) |-> since_wr_reg <= 3'h4)
        else $error("ff table changed without a write");
    oe_cause_a: assert property ($changed(line_oe) |-> since_wr_reg <= 3'h4)
        else $error("line enable changed without a write");
endmodule : porl_router_props

bind porl_router porl_router_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .active_exposure_us(active_exposure_us),
    .active_gain_factor(active_gain_factor), .active_ff_table(active_ff_table),
    .line_oe(line_oe));
`default_nettype wire

// ==== porl_strobe_model.sv ====
// Model: strobe equipment that counts and times pulses on each output line
`timescale 1ns/1ns
`default_nettype none
module porl_strobe_model
    import porl_pkg::*;
(
    input wire logic hclk,
    input wire logic [NUM_LINES-1:0] line_out,
    input wire logic [NUM_LINES-1:0] line_oe
);
    // An open circuit leaves the lamp dark whatever level the stage holds
    logic [NUM_LINES-1:0] lit;
    int pulse_count [NUM_LINES] = '{default: 0};
    int last_width [NUM_LINES] = '{default: 0};
    int run [NUM_LINES] = '{default: 0};
    assign lit = line_out & line_oe;
    always @(posedge hclk)
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            if (lit[i] === 1'b1)
            begin
                if (run[i] == 0)
                    pulse_count[i]++;
                run[i]++;
            end
            else
            begin
                if (run[i] != 0)
                    last_width[i] = run[i];
                run[i] = 0;
            end
        end
    end
endmodule : porl_strobe_model
`default_nettype wire

// ==== test_preset_output_line_router.sv ====
// Testbench: register, preset and output routing tests of the line router
`timescale 1ns/1ns
`default_nettype none
module test_preset_output_line_router;
    import porl_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, active_ff_table;
    logic [2:0] hsize;
    logic [7:0] ev;
    logic [EXP_W-1:0] active_exposure_us;
    logic [GAIN_W-1:0] active_gain_factor;
    logic [NUM_LINES-1:0] line_out, line_oe;
    int n_errors = 0;
    int comparisons = 0;
    int c;
    // Event input bit driven for each source code
    int ev_bit [13] = '{0, 0, 0, 1, 2, 2, 3, 3, 5, 6, 4, 4, 7};

    porl_router i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_active(ev[0]), .line_active(ev[1]), .exposure_active(ev[2]),
        .readout_active(ev[3]), .acq_active(ev[4]), .good_trig_event(ev[5]),
        .bad_trig_event(ev[6]), .tmr_a_done_event(ev[7]),
        .active_exposure_us(active_exposure_us), .active_gain_factor(active_gain_factor),
        .active_ff_table(active_ff_table), .line_out(line_out), .line_oe(line_oe));
    porl_strobe_model i_far (.hclk(hclk), .line_out(line_out), .line_oe(line_oe));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wait_cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_cycles

    // Hold each phase until hready
    task bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus_xfer

    task bus_write(input logic [7:0] a, input logic [31:0] d);
        bus_xfer(1'b1, a, d);
    endtask : bus_write

    task bus_read(input logic [7:0] a);
        bus_xfer(1'b0, a, 32'h0);
    endtask : bus_read

    // f: latch, outputs, ff, gain, exposure cycle bits
    task wr_ctrl(input int p, input int l, input int a, input logic [4:0] f);
        bus_write(OFS_CTRL, {15'h0, f, 1'b0, 3'(a), 2'h0, 2'(l), 1'b0, 3'(p)});
    endtask : wr_ctrl

    task test_done();
        $display("Mismatches: %0d, comparisons: %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        wait_cycles(20000);
        n_errors++;
        test_done();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ev = 8'h00;
        wait_cycles(5);
        hresetn <= 1'b1;
        bus_read(OFS_EXPOSURE);
        check(rd, 32'h64);
        bus_read(OFS_GAIN);
        check(rd, 32'h100);
        check(32'(line_oe), 32'h0);
        bus_write(8'h40, 32'hFFFFFFFF);
        bus_read(8'h40);
        check(rd, 32'h0);
        wr_ctrl(2, 0, 0, 5'h07);
        bus_write(OFS_EXPOSURE, 32'h1234);
        bus_write(OFS_GAIN, 32'h200);
        wr_ctrl(5, 0, 0, 5'h07);
        bus_write(OFS_EXPOSURE, 32'h55);
        bus_write(OFS_GAIN, 32'h80);
        bus_write(OFS_FF_TABLE, 32'h1);
        wr_ctrl(2, 0, 5, 5'h07);
        bus_read(OFS_EXPOSURE);
        check(rd, 32'h1234);
        bus_read(OFS_GAIN);
        check(rd, 32'h200);
        wait_cycles(3);
        check(32'(active_exposure_us), 32'h55);
        check(32'(active_gain_factor), 32'h80);
        check(32'(active_ff_table), 32'h1);
        wr_ctrl(2, 0, 2, 5'h07);
        for (int t = 0; t < 4; t++)
        begin
            bus_write(OFS_FF_TABLE, 32'(t));
            wait_cycles(3);
            check(32'(active_ff_table), 32'(t));
        end
        check(32'(active_exposure_us), 32'h1234);
        wr_ctrl(0, 0, 2, 5'h00);
        bus_read(OFS_EXPOSURE);
        check(rd, 32'h64);
        wait_cycles(3);
        check(32'(active_exposure_us), 32'h64);
        for (int i = 0; i < 4; i++)
        begin
            wr_ctrl(0, i, 0, 5'h00);
            bus_write(OFS_LINE_SRC, 32'(SRC_SW_LEVEL));
            bus_write(OFS_LINE_VAL, 32'h1);
            wait_cycles(2);
            check(32'(line_out & line_oe), 32'((2 << i) - 1));
        end
        bus_read(OFS_STATUS);
        check(32'(rd[3:0]), 32'hF);
        wr_ctrl(0, 0, 0, 5'h10);
        bus_write(OFS_LINE_VAL, 32'h0);
        wait_cycles(4);
        check(32'(line_out[0]), 32'h1);
        bus_write(OFS_LATCH_CMD, 32'h1);
        wait_cycles(3);
        check(32'(line_out[0]), 32'h0);
        for (int i = 1; i < 4; i++)
        begin
            wr_ctrl(0, i, 0, 5'h00);
            bus_write(OFS_LINE_SRC, 32'(SRC_OFF));
        end
        wait_cycles(2);
        check(32'(line_oe), 32'h1);
        wr_ctrl(0, 0, 0, 5'h00);
        // Finish sources stay quiet on a rising level
        for (int s = 2; s <= 12; s++)
        begin
            bus_write(OFS_LINE_SRC, 32'(s));
            c = i_far.pulse_count[0];
            ev[ev_bit[s]] <= 1'b1;
            wait_cycles(30);
            check(32'(i_far.pulse_count[0] - c), (s == 5 || s == 7 || s == 11) ? 0 : 1);
            ev[ev_bit[s]] <= 1'b0;
            wait_cycles(45);
            check(32'(i_far.pulse_count[0] - c), 32'h1);
            check(32'(i_far.last_width[0]), 32'(PULSE_CYCLES));
        end
        bus_write(OFS_LINE_SRC, 32'(SRC_GOOD_TRIG_PULSE));
        c = i_far.pulse_count[0];
        repeat (2)
        begin
            ev[5] <= 1'b1;
            wait_cycles(1);
            ev[5] <= 1'b0;
            wait_cycles(2);
        end
        wait_cycles(79);
        check(32'(i_far.pulse_count[0] - c), 32'h2);
        test_done();
    end
endmodule : test_preset_output_line_router
`default_nettype wire
